/* hdl/qdr_sram_dev.sv */
`timescale 1ns/10ps
`default_nettype none
module qdr_sram_dev #(
  parameter int absent_ns = qdr_pkg::STOP_MIN_NS
) (
  qdr_link_if.dev link,
  input wire logic core_clk_in,
  input wire logic [qdr_pkg::IMP_W-1:0] imp_ref_pin_in,
  output logic [qdr_pkg::IMP_W-1:0] drive_imp_out,
  output logic imp_settled_out,
  output logic dll_locked_out,
  output logic single_clk_out
);
  import qdr_pkg::*;
  localparam int MEM_W = ADDR_W + BEAT_W;
  localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(BURST - 1);
  localparam logic [WD_W-1:0] ABSENT_CYC =
    WD_W'((absent_ns + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);

  // One word per burst beat
  logic [DATA_W-1:0] mem [0:(1<<MEM_W)-1];

  logic doff_b, doff_c, absent_b, tgl_c, rst, kpos, ophase;
  logic [IMP_W-1:0] imp_s;
  logic [3:0] mask_all;
  logic [LANES-1:0] mask_n;
  logic rd_go, wr_go, rd_start, wr_start, rd_act, wr_act;
  logic [ADDR_W-1:0] rd_a, wr_a;
  logic [BEAT_W-1:0] rd_b, wr_b;
  logic [RD_LAT-1:0] rp_v_reg, rp_v_next;
  logic [RD_LAT-1:0][ADDR_W-1:0] rp_a_reg, rp_a_next;
  logic [WR_LAT-1:0] wp_v_reg, wp_v_next;
  logic [WR_LAT-1:0][ADDR_W-1:0] wp_a_reg, wp_a_next;
  logic rd_prev_reg, rd_prev_next, wr_prev_reg, wr_prev_next;
  logic rd_run_reg, rd_run_next, wr_run_reg, wr_run_next;
  logic [BEAT_W-1:0] rd_beat_reg, rd_beat_next, wr_beat_reg, wr_beat_next;
  logic [ADDR_W-1:0] rd_addr_reg, rd_addr_next, wr_addr_reg, wr_addr_next;
  logic [DATA_W-1:0] rd_bus_reg, rd_bus_next;
  logic rd_oe_reg, rd_oe_next;
  logic [1:0] echo_reg, echo_next;
  logic single_reg, single_next, tgl_reg, tgl_next;
  logic locked_reg, locked_next, settled_reg, settled_next;
  logic [LOCK_W-1:0] lock_cnt_reg, lock_cnt_next, imp_cnt_reg, imp_cnt_next;
  logic [IMP_W-1:0] imp_reg, imp_next;
  logic tprev_reg, tprev_next, absent_reg, absent_next;
  logic [WD_W-1:0] idle_reg, idle_next;
  logic locked_c, lock_out_reg, lock_out_next;

  sync2 #(.WIDTH(1)) u_doff_b (
    .clk_in(link.beat_clk), .d_in(link.loop_lock_disable_n), .q_out(doff_b));
  sync2 #(.WIDTH(1)) u_abs_b (
    .clk_in(link.beat_clk), .d_in(absent_reg), .q_out(absent_b));
  sync2 #(.WIDTH(IMP_W)) u_imp (
    .clk_in(link.beat_clk), .d_in(imp_ref_pin_in), .q_out(imp_s));
  sync2 #(.WIDTH(1)) u_doff_c (
    .clk_in(core_clk_in), .d_in(link.loop_lock_disable_n), .q_out(doff_c));
  sync2 #(.WIDTH(1)) u_tgl (
    .clk_in(core_clk_in), .d_in(tgl_reg), .q_out(tgl_c));
  sync2 #(.WIDTH(1)) u_lock (
    .clk_in(core_clk_in), .d_in(locked_reg), .q_out(locked_c));

  assign rst = !doff_b;
  assign kpos = link.in_edge_pos;
  assign mask_all = {link.lane3_mask_n, link.lane2_mask_n, link.lane1_mask_n,
                     link.lane0_mask_n};
  assign mask_n = mask_all[LANES-1:0];
  // Output phase from output clocks, or from input clocks when strapped
  assign ophase = single_reg ? kpos : link.out_clk_pos;

  always_comb begin
    // Commands only with select high at the previous K-high edge
    rd_go = kpos && !link.fetch_sel_n && rd_prev_reg;
    wr_go = kpos && !link.store_sel_n && wr_prev_reg;
    rd_prev_next = kpos ? link.fetch_sel_n : rd_prev_reg;
    wr_prev_next = kpos ? link.store_sel_n : wr_prev_reg;
    // Separate pipelines, one per port
    rp_v_next = {rp_v_reg[RD_LAT-2:0], rd_go};
    rp_a_next = {rp_a_reg[RD_LAT-2:0], link.addr_in};
    wp_v_next = {wp_v_reg[WR_LAT-2:0], wr_go};
    wp_a_next = {wp_a_reg[WR_LAT-2:0], link.addr_in};
    rd_start = rp_v_reg[RD_LAT-1];
    rd_act = rd_start || rd_run_reg;
    rd_a = rd_start ? rp_a_reg[RD_LAT-1] : rd_addr_reg;
    rd_b = rd_start ? '0 : rd_beat_reg;
    rd_addr_next = rd_a;
    rd_beat_next = rd_b + 1'b1;
    rd_run_next = rd_act && (rd_b != LAST_BEAT);
    // Bus released once the last beat is gone
    rd_oe_next = rd_act;
    rd_bus_next = rd_act ? mem[{rd_a, rd_b}] : rd_bus_reg;
    wr_start = wp_v_reg[WR_LAT-1];
    wr_act = wr_start || wr_run_reg;
    wr_a = wr_start ? wp_a_reg[WR_LAT-1] : wr_addr_reg;
    wr_b = wr_start ? '0 : wr_beat_reg;
    wr_addr_next = wr_a;
    wr_beat_next = wr_b + 1'b1;
    wr_run_next = wr_act && (wr_b != LAST_BEAT);
    echo_next = {!ophase, ophase};
    tgl_next = !tgl_reg;
    single_next = single_reg;
    // Loop lock counted in K cycles
    lock_cnt_next = lock_cnt_reg;
    locked_next = locked_reg;
    if (kpos && !locked_reg) begin
      lock_cnt_next = lock_cnt_reg + 1'b1;
      locked_next = (lock_cnt_reg == LOCK_W'(LOCK_KCYC - 1));
    end
    // Settling counts K cycles with outputs idle
    imp_cnt_next = imp_cnt_reg;
    settled_next = settled_reg;
    if (kpos && !rd_oe_reg && !settled_reg) begin
      imp_cnt_next = imp_cnt_reg + 1'b1;
      settled_next = (imp_cnt_reg == LOCK_W'(IMP_KCYC - 1));
    end
    imp_next = (!rd_oe_reg && !rd_act) ? imp_s : imp_reg;
    if (absent_b) begin
      lock_cnt_next = '0;
      locked_next = 1'b0;
    end
    if (rst) begin
      rp_v_next = '0;
      wp_v_next = '0;
      rd_run_next = 1'b0;
      wr_run_next = 1'b0;
      rd_oe_next = 1'b0;
      rd_prev_next = 1'b1;
      wr_prev_next = 1'b1;
      // Strap caught while the loop is held disabled
      single_next = link.out_clk_pos && link.out_clk_neg;
      lock_cnt_next = '0;
      locked_next = 1'b0;
      imp_cnt_next = '0;
      settled_next = 1'b0;
      imp_next = IMP_RESET;
      tgl_next = 1'b0;
    end
  end

  // No edges while the clock stands, so every state holds
  always_ff @(posedge link.beat_clk) begin
    rp_v_reg <= rp_v_next;
    rp_a_reg <= rp_a_next;
    wp_v_reg <= wp_v_next;
    wp_a_reg <= wp_a_next;
    rd_prev_reg <= rd_prev_next;
    wr_prev_reg <= wr_prev_next;
    rd_run_reg <= rd_run_next;
    wr_run_reg <= wr_run_next;
    rd_beat_reg <= rd_beat_next;
    wr_beat_reg <= wr_beat_next;
    rd_addr_reg <= rd_addr_next;
    wr_addr_reg <= wr_addr_next;
    rd_bus_reg <= rd_bus_next;
    rd_oe_reg <= rd_oe_next;
    echo_reg <= echo_next;
    single_reg <= single_next;
    tgl_reg <= tgl_next;
    lock_cnt_reg <= lock_cnt_next;
    locked_reg <= locked_next;
    imp_cnt_reg <= imp_cnt_next;
    settled_reg <= settled_next;
    imp_reg <= imp_next;
  end

  // Late write, one beat per edge, lanes gated by their masks
  always_ff @(posedge link.beat_clk) begin
    if (wr_act && !rst) begin
      for (int l = 0; l < LANES; l++) begin
        if (!mask_n[l]) begin
          mem[{wr_a, wr_b}][l*LANE_W +: LANE_W] <= link.wr_bus_in[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Watchdog on the core clock: no beat toggle for long enough
  always_comb begin
    tprev_next = tgl_c;
    idle_next = idle_reg;
    absent_next = absent_reg;
    // Lock status seen here, so it drops while the beat clock stands
    lock_out_next = locked_c && !absent_reg;
    if (tgl_c != tprev_reg) begin
      idle_next = '0;
      // Absence held until the beat side has dropped its lock
      absent_next = absent_reg && locked_c;
    end else if (idle_reg != ABSENT_CYC) begin
      idle_next = idle_reg + 1'b1;
    end else begin
      absent_next = 1'b1;
    end
    if (!doff_c) begin
      idle_next = '0;
      absent_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    tprev_reg <= tprev_next;
    idle_reg <= idle_next;
    absent_reg <= absent_next;
    lock_out_reg <= lock_out_next;
  end

  assign link.rd_bus_out = rd_bus_reg;
  assign link.rd_oe = rd_oe_reg;
  assign link.echo_strobe_pos = echo_reg[0];
  assign link.echo_strobe_neg = echo_reg[1];
  assign drive_imp_out = imp_reg;
  assign imp_settled_out = settled_reg;
  assign dll_locked_out = lock_out_reg;
  assign single_clk_out = single_reg;
endmodule // qdr_sram_dev
`default_nettype wire

/* include/qdr_pkg.sv */
package qdr_pkg;
  localparam bit ORG_WIDE = 1'b1;
  localparam int DATA_W = ORG_WIDE ? 36 : 18;
  localparam int ADDR_W = ORG_WIDE ? 22 : 23;
  localparam int LANE_W = 9;
  localparam int LANES = DATA_W / LANE_W;
  localparam int BURST = 4;
  localparam int BEAT_W = 2;
  localparam int RD_LAT = 2;
  localparam int WR_LAT = 2;
  localparam int LOCK_KCYC = 1024;
  localparam int IMP_KCYC = 1024;
  localparam int LOCK_W = 10;
  localparam int IMP_W = 5;
  localparam logic [IMP_W-1:0] IMP_RESET = 5'h10;
  localparam int CORE_PERIOD_NS = 4;
  localparam int STOP_MIN_NS = 30;
  localparam int STOP_MIN_CYC = (STOP_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int BEAT_CORE = 2;
  localparam int RELOCK_CYC = LOCK_KCYC * 2 * BEAT_CORE;
  localparam int DOFF_HOLD_CYC = 16;
  localparam int CNT_W = 13;
  localparam int WD_W = 8;
  typedef enum {C_POR, C_LOCK, C_IDLE, C_BUSY, C_STOP} ctl_state_t;
endpackage

/* include/qdr_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface qdr_link_if;
  logic beat_clk;
  logic in_edge_pos;
  logic out_clk_pos;
  logic out_clk_neg;
  logic fetch_sel_n;
  logic store_sel_n;
  logic [qdr_pkg::ADDR_W-1:0] addr_in;
  logic [qdr_pkg::DATA_W-1:0] wr_bus_in;
  logic lane0_mask_n;
  logic lane1_mask_n;
  logic lane2_mask_n;
  logic lane3_mask_n;
  logic loop_lock_disable_n;
  logic [qdr_pkg::DATA_W-1:0] rd_bus_out;
  logic rd_oe;
  logic echo_strobe_pos;
  logic echo_strobe_neg;
  modport dev (
    input beat_clk, in_edge_pos, out_clk_pos, out_clk_neg, fetch_sel_n, store_sel_n,
    input addr_in, wr_bus_in, lane0_mask_n, lane1_mask_n, lane2_mask_n, lane3_mask_n,
    input loop_lock_disable_n,
    output rd_bus_out, rd_oe, echo_strobe_pos, echo_strobe_neg
  );
  modport ctl (
    output beat_clk, in_edge_pos, out_clk_pos, out_clk_neg, fetch_sel_n, store_sel_n,
    output addr_in, wr_bus_in, lane0_mask_n, lane1_mask_n, lane2_mask_n, lane3_mask_n,
    output loop_lock_disable_n,
    input rd_bus_out, rd_oe, echo_strobe_pos, echo_strobe_neg
  );
endinterface
`default_nettype wire

/* hdl/sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] stage_reg;
  logic [WIDTH-1:0] q_reg;
  always_ff @(posedge clk_in) begin
    stage_reg <= d_in;
    q_reg <= stage_reg;
  end
  assign q_out = q_reg;
endmodule // sync2
`default_nettype wire

/* hdl/qdr_ctl.sv */
`timescale 1ns/10ps
`default_nettype none
module qdr_ctl (
  qdr_link_if.ctl link,
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic single_clk_in,
  input wire logic clk_stop_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [qdr_pkg::ADDR_W-1:0] cmd_addr_in,
  input wire logic [qdr_pkg::BURST*qdr_pkg::DATA_W-1:0] cmd_wdata_in,
  input wire logic [qdr_pkg::BURST*qdr_pkg::LANES-1:0] cmd_mask_n_in,
  output logic cmd_ready_out,
  output logic rd_valid_out,
  output logic [qdr_pkg::BURST*qdr_pkg::DATA_W-1:0] rd_data_out,
  output logic link_ready_out
);
  import qdr_pkg::*;
  localparam int BW = BURST * DATA_W;
  ctl_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] seq_reg, seq_next;
  logic [1:0] rcnt_reg, rcnt_next;
  logic run_reg, run_next, beat_reg, beat_next, k_reg, k_next, oclk_reg, oclk_next;
  logic single_reg, single_next, single_s, doff_reg, doff_next, wr_reg, wr_next;
  logic rsel_reg, rsel_next, wsel_reg, wsel_next, ready_reg, ready_next;
  logic rv_reg, rv_next, upd;
  logic oclkn_reg, oclkn_next, link_rdy_reg, link_rdy_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [BW-1:0] wdat_reg, wdat_next, rdat_reg, rdat_next;
  logic [BURST*LANES-1:0] wmask_reg, wmask_next;
  logic [DATA_W-1:0] bus_reg, bus_next;
  logic [3:0] lane_reg, lane_next;
  logic [DATA_W:0] rd_s;

  sync2 #(.WIDTH(1)) u_strap (.clk_in(core_clk_in), .d_in(single_clk_in), .q_out(single_s));
  sync2 #(.WIDTH(DATA_W+1)) u_rd (
    .clk_in(core_clk_in), .d_in({link.rd_oe, link.rd_bus_out}), .q_out(rd_s));

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 1'b1;
    seq_next = seq_reg;
    run_next = run_reg;
    // Beat clock toggles every core cycle, the fastest division available
    beat_next = run_reg ? !beat_reg : 1'b0;
    upd = run_reg && beat_reg;
    k_next = upd ? !k_reg : k_reg;
    single_next = single_reg;
    doff_next = doff_reg;
    rsel_next = rsel_reg;
    wsel_next = wsel_reg;
    addr_next = addr_reg;
    wr_next = wr_reg;
    wdat_next = wdat_reg;
    wmask_next = wmask_reg;
    bus_next = bus_reg;
    lane_next = lane_reg;
    rcnt_next = rcnt_reg;
    rdat_next = rdat_reg;
    rv_next = 1'b0;
    // Collect one returned beat per beat period
    if (beat_reg && rd_s[DATA_W]) begin
      rdat_next = {rd_s[DATA_W-1:0], rdat_reg[BW-1:DATA_W]};
      rcnt_next = rcnt_reg + 1'b1;
      rv_next = (rcnt_reg == 2'(BURST - 1));
    end
    unique case (state_reg)
      C_POR: if (cnt_reg == CNT_W'(DOFF_HOLD_CYC)) begin
        doff_next = 1'b1;
        state_next = C_LOCK;
        cnt_next = '0;
      end
      C_LOCK: if (cnt_reg == CNT_W'(RELOCK_CYC - 1)) begin
        state_next = C_IDLE;
      end
      C_IDLE: begin
        if (cmd_valid_in && ready_reg) begin
          // One command per burst keeps selects high at the prior edge
          rsel_next = cmd_write_in;
          wsel_next = !cmd_write_in;
          addr_next = cmd_addr_in;
          wr_next = cmd_write_in;
          wdat_next = cmd_wdata_in;
          wmask_next = cmd_mask_n_in;
          seq_next = 3'h1;
          state_next = C_BUSY;
        end else if (clk_stop_in && !beat_reg) begin
          run_next = 1'b0;
          beat_next = 1'b0;
          state_next = C_STOP;
          cnt_next = '0;
        end
      end
      C_BUSY: begin
        if (upd) begin
          rsel_next = 1'b1;
          wsel_next = 1'b1;
          seq_next = seq_reg + 1'b1;
          lane_next = 4'hf;
          if (wr_reg && seq_reg >= 3'(WR_LAT) && seq_reg < 3'(WR_LAT + BURST)) begin
            // Late data and masks, one beat per edge
            bus_next = wdat_reg[DATA_W-1:0];
            lane_next[LANES-1:0] = wmask_reg[LANES-1:0];
            wdat_next = wdat_reg >> DATA_W;
            wmask_next = wmask_reg >> LANES;
          end
          if (wr_reg && seq_reg == 3'(WR_LAT + BURST)) begin
            state_next = C_IDLE;
          end
        end
        if (rv_next) begin
          state_next = C_IDLE;
        end
      end
      C_STOP: if (!clk_stop_in && cnt_reg >= CNT_W'(STOP_MIN_CYC)) begin
        // Long enough stop resets the loop, so relock before use
        run_next = 1'b1;
        state_next = C_LOCK;
        cnt_next = '0;
      end
    endcase
    if (state_reg == C_STOP && state_next == C_STOP) begin
      cnt_next = (cnt_reg == '1) ? cnt_reg : cnt_next;
    end
    oclk_next = single_reg ? 1'b1 : k_next;
    oclkn_next = single_reg ? 1'b1 : !k_next;
    ready_next = (state_next == C_IDLE) && run_next && beat_next && !k_next;
    if (reset_in) begin
      state_next = C_POR;
      cnt_next = '0;
      seq_next = '0;
      run_next = 1'b1;
      beat_next = 1'b0;
      k_next = 1'b0;
      single_next = single_s;
      oclk_next = single_s;
      oclkn_next = 1'b1;
      doff_next = 1'b0;
      rsel_next = 1'b1;
      wsel_next = 1'b1;
      addr_next = '0;
      wr_next = 1'b0;
      bus_next = '0;
      lane_next = 4'hf;
      rcnt_next = '0;
      rv_next = 1'b0;
      ready_next = 1'b0;
    end
    link_rdy_next = (state_next == C_IDLE);
  end

  always_ff @(posedge core_clk_in) begin
    state_reg <= state_next;
    cnt_reg <= cnt_next;
    seq_reg <= seq_next;
    run_reg <= run_next;
    beat_reg <= beat_next;
    k_reg <= k_next;
    oclk_reg <= oclk_next;
    oclkn_reg <= oclkn_next;
    link_rdy_reg <= link_rdy_next;
    single_reg <= single_next;
    doff_reg <= doff_next;
    rsel_reg <= rsel_next;
    wsel_reg <= wsel_next;
    addr_reg <= addr_next;
    wr_reg <= wr_next;
    wdat_reg <= wdat_next;
    wmask_reg <= wmask_next;
    bus_reg <= bus_next;
    lane_reg <= lane_next;
    rcnt_reg <= rcnt_next;
    rdat_reg <= rdat_next;
    rv_reg <= rv_next;
    ready_reg <= ready_next;
  end

  assign link.beat_clk = beat_reg;
  assign link.in_edge_pos = k_reg;
  assign link.out_clk_pos = oclk_reg;
  assign link.out_clk_neg = oclkn_reg;
  assign link.fetch_sel_n = rsel_reg;
  assign link.store_sel_n = wsel_reg;
  assign link.addr_in = addr_reg;
  assign link.wr_bus_in = bus_reg;
  assign link.lane0_mask_n = lane_reg[0];
  assign link.lane1_mask_n = lane_reg[1];
  assign link.lane2_mask_n = lane_reg[2];
  assign link.lane3_mask_n = lane_reg[3];
  assign link.loop_lock_disable_n = doff_reg;
  assign cmd_ready_out = ready_reg;
  assign rd_valid_out = rv_reg;
  assign rd_data_out = rdat_reg;
  assign link_ready_out = link_rdy_reg;
endmodule // qdr_ctl
`default_nettype wire

/* tb/qdr_link_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module qdr_link_chk (
  input wire logic beat_clk,
  input wire logic in_edge_pos,
  input wire logic out_clk_pos,
  input wire logic out_clk_neg,
  input wire logic fetch_sel_n,
  input wire logic store_sel_n,
  input wire logic loop_lock_disable_n,
  input wire logic rd_oe,
  input wire logic echo_strobe_pos,
  input wire logic echo_strobe_neg
);
  default clocking @(posedge beat_clk);
  endclocking
  default disable iff (!loop_lock_disable_n);

  // Read accepted at a K-high edge
  sequence rd_take_s;
    in_edge_pos && !fetch_sel_n && $past(fetch_sel_n, 2);
  endsequence

  cmd_latency_a: assert property (rd_take_s |-> ##3 rd_oe [*4])
    else $error("read burst not driven for four beats two beats after command");
  burst_end_a: assert property (rd_take_s ##4 fetch_sel_n |-> ##3 !rd_oe)
    else $error("read bus still driven after the last burst ended");
  read_cause_a: assert property ($rose(rd_oe) |-> $past(in_edge_pos && !fetch_sel_n, 3))
    else $error("read bus driven without a read command two beats before");
  oe_edge_a: assert property ($changed(rd_oe) |-> $past(in_edge_pos))
    else $error("read bus enable changed away from a K-high edge");
  echo_pair_a: assert property (rd_oe |->
    echo_strobe_neg == !echo_strobe_pos &&
    echo_strobe_pos == $past(out_clk_neg ? (out_clk_pos && in_edge_pos) : out_clk_pos))
    else $error("echo pair not complementary during read data");
  echo_toggle_a: assert property ((rd_oe && $past(rd_oe)) |->
    echo_strobe_pos != $past(echo_strobe_pos))
    else $error("echo clock did not toggle with a read beat");
  fetch_spacing_a: assert property ((in_edge_pos && !fetch_sel_n) |-> $past(fetch_sel_n, 2))
    else $error("read select low on two consecutive K-high edges");
  store_spacing_a: assert property ((in_edge_pos && !store_sel_n) |-> $past(store_sel_n, 2))
    else $error("write select low on two consecutive K-high edges");
  sel_phase_a: assert property ((!fetch_sel_n || !store_sel_n) |-> in_edge_pos)
    else $error("select low at a complementary edge");
  single_clk_a: assert property ((out_clk_pos && out_clk_neg) |=> (out_clk_pos && out_clk_neg))
    else $error("output clocks left the single clock level");
endmodule // qdr_link_chk
`default_nettype wire

/* tb/ddr_split_port_sram_burst4_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ddr_split_port_sram_burst4_tb;
  import qdr_pkg::*;
  localparam int BW = BURST * DATA_W;
  localparam logic [ADDR_W-1:0] A_LO = 22'h000001;
  localparam logic [ADDR_W-1:0] A_HI = 22'h3fffff;
  localparam logic [ADDR_W-1:0] A_MID = 22'h155555;
  localparam logic [ADDR_W-1:0] A_SGL = 22'h2aaaaa;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic single_clk_in = 1'b0;
  logic clk_stop_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic cmd_write_in = 1'b0;
  logic [ADDR_W-1:0] cmd_addr_in = '0;
  logic [BW-1:0] cmd_wdata_in = '0;
  logic [BURST*LANES-1:0] cmd_mask_n_in = '1;
  logic [IMP_W-1:0] imp_ref_pin_in = 5'h0a;
  logic cmd_ready_out, rd_valid_out, link_ready_out;
  logic [BW-1:0] rd_data_out;
  logic [IMP_W-1:0] drive_imp_out;
  logic imp_settled_out, dll_locked_out, single_clk_out;
  int bad_count = 0;
  int n_tests = 0;
  logic [BW-1:0] shadow [logic [ADDR_W-1:0]];
  logic [15:0] masks [4] = '{16'hfffe, 16'h7bde, 16'hffff, 16'ha5a5};

  qdr_link_if link ();
  qdr_ctl qdr_ctl_inst (.link(link.ctl), .core_clk_in(core_clk_in), .reset_in(reset_in),
    .single_clk_in(single_clk_in), .clk_stop_in(clk_stop_in), .cmd_valid_in(cmd_valid_in),
    .cmd_write_in(cmd_write_in), .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
    .cmd_mask_n_in(cmd_mask_n_in), .cmd_ready_out(cmd_ready_out),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .link_ready_out(link_ready_out));
  qdr_sram_dev qdr_sram_dev_inst (.link(link.dev), .core_clk_in(core_clk_in),
    .imp_ref_pin_in(imp_ref_pin_in), .drive_imp_out(drive_imp_out),
    .imp_settled_out(imp_settled_out), .dll_locked_out(dll_locked_out),
    .single_clk_out(single_clk_out));
  qdr_link_chk qdr_link_chk_inst (.beat_clk(link.beat_clk), .in_edge_pos(link.in_edge_pos),
    .out_clk_pos(link.out_clk_pos), .out_clk_neg(link.out_clk_neg),
    .fetch_sel_n(link.fetch_sel_n), .store_sel_n(link.store_sel_n),
    .loop_lock_disable_n(link.loop_lock_disable_n), .rd_oe(link.rd_oe),
    .echo_strobe_pos(link.echo_strobe_pos), .echo_strobe_neg(link.echo_strobe_neg));

  always #2 core_clk_in = ~core_clk_in;

  function automatic logic [BW-1:0] pat(input logic [7:0] s);
    for (int k = 0; k < BURST; k++) begin
      pat[k*DATA_W +: DATA_W] = {s, s ^ 8'(k + 1), 20'ha5c3e};
    end
  endfunction

  task automatic compare_word(input logic [BW-1:0] got, input logic [BW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_code(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected status at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wait_link();
    int n;
    n = 0;
    while (link_ready_out !== 1'b1 && n < 6000) begin
      @(posedge core_clk_in);
      n++;
    end
    compare_code(8'(n < 6000), 8'h01);
  endtask

  // Holds the command until an edge samples ready high
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [BW-1:0] d,
                       input logic [BURST*LANES-1:0] m);
    int n;
    n = 0;
    cmd_valid_in <= 1'b1;
    cmd_write_in <= wr;
    cmd_addr_in <= a;
    cmd_wdata_in <= d;
    cmd_mask_n_in <= m;
    @(posedge core_clk_in);
    while (cmd_ready_out !== 1'b1 && n < 200) begin
      @(posedge core_clk_in);
      n++;
    end
    cmd_valid_in <= 1'b0;
    compare_code(8'(n < 200), 8'h01);
    @(posedge core_clk_in);
  endtask

  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [BW-1:0] d,
                          input logic [BURST*LANES-1:0] m);
    logic [BW-1:0] old;
    old = shadow.exists(a) ? shadow[a] : '0;
    issue(1'b1, a, d, m);
    for (int k = 0; k < BURST * LANES; k++) begin
      if (!m[k]) begin
        old[k*LANE_W +: LANE_W] = d[k*LANE_W +: LANE_W];
      end
    end
    shadow[a] = old;
  endtask

  task automatic do_read(input logic [ADDR_W-1:0] a, output logic [BW-1:0] q);
    int n;
    n = 0;
    issue(1'b0, a, '0, '1);
    while (rd_valid_out !== 1'b1 && n < 100) begin
      @(posedge core_clk_in);
      n++;
    end
    compare_code(8'(n < 100), 8'h01);
    q = rd_data_out;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk_in);
    bad_count++;
    $display("unexpected hang at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end_of_test();
  end

  initial begin
    logic [BW-1:0] q;
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    wait_link();
    repeat (40) @(posedge core_clk_in);
    compare_code(8'(dll_locked_out), 8'h01);
    compare_code(8'(imp_settled_out), 8'h01);
    compare_code(8'(single_clk_out), 8'h00);
    compare_code(8'(drive_imp_out), 8'h0a);
    do_write(A_LO, pat(8'h11), '0);
    do_write(A_HI, pat(8'h22), '0);
    do_read(A_LO, q);
    compare_word(q, shadow[A_LO]);
    do_read(A_HI, q);
    compare_word(q, shadow[A_HI]);
    for (int i = 0; i < 4; i++) begin
      do_write(A_LO, pat(8'h30 + 8'(i)), masks[i]);
      do_read(A_LO, q);
      compare_word(q, shadow[A_LO]);
    end
    do_write(A_MID, pat(8'h44), '0);
    do_read(A_HI, q);
    compare_word(q, shadow[A_HI]);
    do_read(A_MID, q);
    compare_word(q, shadow[A_MID]);
    imp_ref_pin_in <= 5'h15;
    repeat (100) @(posedge core_clk_in);
    compare_code(8'(drive_imp_out), 8'h15);
    clk_stop_in <= 1'b1;
    repeat (40) @(posedge core_clk_in);
    compare_code(8'(link_ready_out), 8'h00);
    compare_code(8'(dll_locked_out), 8'h00);
    clk_stop_in <= 1'b0;
    wait_link();
    repeat (40) @(posedge core_clk_in);
    compare_code(8'(dll_locked_out), 8'h01);
    do_read(A_LO, q);
    compare_word(q, shadow[A_LO]);
    reset_in <= 1'b1;
    single_clk_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    wait_link();
    compare_code(8'(single_clk_out), 8'h01);
    do_write(A_SGL, pat(8'h55), '0);
    do_read(A_SGL, q);
    compare_word(q, shadow[A_SGL]);
    end_of_test();
  end
endmodule // ddr_split_port_sram_burst4_tb
`default_nettype wire
